// >>> bench/adc_conversion_host_port_test.sv
// Purpose: self-checking bench of the host port
// Assumes: converter model answers within 40 cycles
// Notes: stuck path waits out the full 12 us timeout
`default_nettype none
`define chk(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module adc_conversion_host_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = '0, rst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
	logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0, stuck = '0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic option_fitted = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, adc_start, adc_done_n, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] adc_config;
	logic [11:0] adc_data, value = '0;
	int n_errors = 0, samples_checked = 0;
	adc_conversion_host_port uut (.core_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .adc_config, .adc_start, .adc_done_n, .adc_data,
		.option_fitted, .irq);
	adc_model far (.core_clk, .adc_start, .stuck, .value, .adc_done_n, .adc_data);
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task tmo(input int n, input int lim);
		if (n >= lim) begin
			n_errors++;
			end_sim;
		end
	endtask
	task bus_wr(input logic [29:0] i, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_go;
		logic w_go;
		logic b_go;
		@(posedge core_clk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge core_clk);
			aw_go = s_axi_awvalid && s_axi_awready;
			w_go = s_axi_wvalid && s_axi_wready;
			b_go = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
			if (aw_go) s_axi_awvalid <= 1'b0;
			if (w_go) s_axi_wvalid <= 1'b0;
			if (b_go) break;
		end
		s_axi_bready <= 1'b0;
		tmo(n, 200);
	endtask
	task bus_rd(input logic [29:0] i, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar_go;
		logic r_go;
		@(posedge core_clk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge core_clk);
			ar_go = s_axi_arvalid && s_axi_arready;
			r_go = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge core_clk);
			if (ar_go) s_axi_arvalid <= 1'b0;
			if (r_go) break;
		end
		s_axi_rready <= 1'b0;
		tmo(n, 200);
	endtask
	task wait_idle;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		for (n = 0; n < 2000; n++) begin
			bus_rd(adc_host_pkg::IDX_DONE_STATUS, d, r);
			if (d[7] === 1'b0) break;
		end
		tmo(n, 2000);
	endtask
	task t_misc;
		logic [31:0] d;
		logic [1:0] r;
		bus_rd(adc_host_pkg::IDX_OPTION, d, r);
		`chk(d[0], 1'b1)
		bus_rd(30'h0000_0123, d, r);
		`chk(r, adc_host_pkg::RESP_SLVERR)
		bus_wr(adc_host_pkg::IDX_DONE_STATUS, 32'h0, r);
		`chk(r, adc_host_pkg::RESP_SLVERR)
	endtask
	task t_conv;
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] c;
		logic [11:0] v;
		logic [15:0] e;
		bus_wr(adc_host_pkg::IDX_IRQ_MASK, 32'h1, r);
		for (int k = 0; k < 8; k++) begin
			c = {3'h2, k[1:0], k[2:0]};
			v = {k[2:0], 9'h0a5};
			e = c[3] ? {{4{v[11]}}, v} : {4'h0, v};
			value <= v;
			bus_wr(adc_host_pkg::IDX_CONTROL, {24'h0, c}, r);
			`chk(adc_config, c)
			bus_rd(adc_host_pkg::IDX_DONE_STATUS, d, r);
			`chk(d[7], 1'b1)
			wait_idle;
			`chk(irq, 1'b1)
			bus_rd(adc_host_pkg::IDX_CONTROL, d, r);
			`chk(d, {16'h0, e})
			bus_rd(adc_host_pkg::IDX_RESULT_HIGH, d, r);
			`chk(d, {24'h0, e[15:8]})
			bus_rd(adc_host_pkg::IDX_IRQ_STATUS, d, r);
			`chk(d[1:0], 2'h1)
			`chk(irq, 1'b0)
		end
	endtask
	task t_tmo;
		logic [31:0] d;
		logic [1:0] r;
		stuck <= 1'b1;
		bus_wr(adc_host_pkg::IDX_CONTROL, 32'h5f, r);
		bus_wr(adc_host_pkg::IDX_CONTROL, 32'h41, r);
		`chk(adc_config, 8'h5f)
		wait_idle;
		`chk(irq, 1'b0)
		bus_rd(adc_host_pkg::IDX_IRQ_STATUS, d, r);
		`chk(d[1:0], 2'h2)
		bus_rd(adc_host_pkg::IDX_CONTROL, d, r);
		`chk(d, 32'hfea5)
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_misc;
		t_conv;
		t_tmo;
		end_sim;
	end
endmodule
`default_nettype wire

// >>> bench/adc_host_monitor.sv
// Purpose: handshake and start checks at the host port
// Assumes: one clock, reset active low
// Notes: busy is internal, so the bench judges it
`default_nettype none
module adc_host_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic adc_start,
	input wire logic irq
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_rh; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata);
	endproperty
	property p_ar; s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_aw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_bd; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	property p_rd; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	// A start pulse must never stretch or repeat at once
	property p_st; adc_start |=> !adc_start [*3]; endproperty
	property p_sb; adc_start |-> s_axi_bvalid && s_axi_bresp == 2'h0;
	endproperty
	a_bh: assert property (p_bh) else $error("bvalid dropped");
	a_rh: assert property (p_rh) else $error("rdata moved");
	a_ar: assert property (p_ar) else $error("arready while rvalid");
	a_aw: assert property (p_aw) else $error("write ready while bvalid");
	a_bd: assert property (p_bd) else $error("bvalid repeated");
	a_rd: assert property (p_rd) else $error("rvalid repeated");
	a_st: assert property (p_st) else $error("start too long");
	a_sb: assert property (p_sb) else $error("start without write");
	c_st: cover property (adc_start);
	c_irq: cover property ($rose(irq));
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind adc_conversion_host_port adc_host_monitor mon (.core_clk, .rst_n,
	.s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.adc_start, .irq);
`default_nettype wire

// >>> bench/adc_model.sv
// Purpose: converter on the pin side
// Assumes: result held until the next start
// Notes: stuck stands for a converter that never ends
`default_nettype none
module adc_model (
	input wire logic core_clk,
	input wire logic adc_start,
	input wire logic stuck,
	input wire logic [11:0] value,
	output logic adc_done_n,
	output logic [11:0] adc_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial adc_done_n = 1'b1;
	initial adc_data = 12'h000;
	always @(posedge core_clk) begin
		if (adc_start) begin
			adc_done_n <= 1'b1;
			adc_data <= ~adc_data; // No valid result mid conversion
			cnt <= 40;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 3) adc_data <= value;
			if (cnt == 1 && !stuck) adc_done_n <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/adc_conversion_host_port.sv
// Purpose: register port that starts and reads an external converter
// Assumes: converter drives end of conversion low and holds its result
// Notes: one conversion at a time; starts while busy are ignored
//
// Implementation choice: the AXI4-Lite register port.
`default_nettype none
module adc_conversion_host_port (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] adc_config,
	output logic adc_start,
	input wire logic adc_done_n,
	input wire logic [11:0] adc_data,
	input wire logic option_fitted,
	output logic irq
);
	typedef enum logic [1:0] {IDLE, START, CONVERT} conv_state_t;

	localparam int COUNT_W_LOCAL = adc_host_pkg::COUNT_W;

	conv_state_t state;
	logic aw_held;
	logic w_held;
	logic [29:0] aw_index;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [7:0] control;
	logic [15:0] result;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [COUNT_W_LOCAL-1:0] conv_count;
	logic done_meta;
	logic done_sync;
	logic [11:0] data_meta;
	logic [11:0] data_sync;
	logic opt_meta;
	logic opt_sync;

	logic aw_hs;
	logic w_hs;
	logic write_fire;
	logic read_fire;
	logic [29:0] wr_index;
	logic [29:0] rd_index;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic start_req;
	logic busy;
	logic conv_end;
	logic conv_timeout;
	logic status_read;
	logic [31:0] next_rdata;
	logic next_rerr;

	// Handshakes; both write halves taken in either order
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign read_fire = s_axi_arvalid && s_axi_arready;
	assign write_fire = (aw_held || aw_hs) && (w_held || w_hs);
	assign wr_index = aw_held ? aw_index : s_axi_awaddr[31:2];
	assign wr_data = w_held ? w_data : s_axi_wdata;
	assign wr_strb = w_held ? w_strb : s_axi_wstrb;
	assign rd_index = s_axi_araddr[31:2];

	assign busy = (state != IDLE);
	assign start_req = write_fire && wr_index == adc_host_pkg::IDX_CONTROL
		&& wr_strb[0] && !busy;
	assign conv_end = state == CONVERT && !done_sync;
	assign conv_timeout = busy && !conv_end
		&& conv_count == COUNT_W_LOCAL'(adc_host_pkg::CONV_CYCLES);
	assign status_read = read_fire
		&& rd_index == adc_host_pkg::IDX_IRQ_STATUS;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
		end else if (write_fire) begin
			aw_held <= 1'b0;
		end else if (aw_hs) begin
			aw_held <= 1'b1;
		end
	end

	// Address kept for a data beat that comes later
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_index <= 30'h0;
		end else if (aw_hs && !write_fire) begin
			aw_index <= s_axi_awaddr[31:2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_held <= 1'b0;
		end else if (write_fire) begin
			w_held <= 1'b0;
		end else if (w_hs) begin
			w_held <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (w_hs && !write_fire) begin
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
	end

	// Write response; read-only and unmapped targets answer SLVERR
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
		end else if (write_fire) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bresp <= adc_host_pkg::RESP_OKAY;
		end else if (write_fire) begin
			s_axi_bresp <= (wr_index == adc_host_pkg::IDX_CONTROL
				|| wr_index == adc_host_pkg::IDX_IRQ_MASK)
				? adc_host_pkg::RESP_OKAY : adc_host_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= adc_host_pkg::IRQ_RESET;
		end else if (write_fire && wr_strb[0]
			&& wr_index == adc_host_pkg::IDX_IRQ_MASK) begin
			irq_mask <= wr_data[1:0];
		end
	end

	// Pin inputs pass two flops before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			done_meta <= 1'b1;
			done_sync <= 1'b1;
		end else begin
			done_meta <= adc_done_n;
			done_sync <= done_meta;
		end
	end

	// Data word is only used once done is seen, so it has settled
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_meta <= 12'h000;
			data_sync <= 12'h000;
		end else begin
			data_meta <= adc_data;
			data_sync <= data_meta;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			opt_meta <= 1'b0;
			opt_sync <= 1'b0;
		end else begin
			opt_meta <= option_fitted;
			opt_sync <= opt_meta;
		end
	end

	// Sequencer; START waits for the converter to go busy,
	// so a done level left from the last conversion is not taken
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= IDLE;
		end else begin
			case (state)
				IDLE: begin
					if (start_req) begin
						state <= START;
					end
				end
				START: begin
					if (conv_timeout) begin
						state <= IDLE;
					end else if (done_sync) begin
						state <= CONVERT;
					end
				end
				CONVERT: begin
					if (conv_end || conv_timeout) begin
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// Cycles since the start, both waiting states counted
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_count <= '0;
		end else if (busy) begin
			conv_count <= conv_count + 1'b1;
		end else begin
			conv_count <= '0;
		end
	end

	// Whole control byte goes to the converter; mode bits are the host's
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			control <= adc_host_pkg::CONTROL_RESET;
		end else if (start_req) begin
			control <= wr_data[7:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= start_req;
		end
	end
	assign adc_config = control;

	// Result formatting by polarity of the running conversion
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			result <= adc_host_pkg::RESULT_RESET;
		end else if (conv_end) begin
			if (control[adc_host_pkg::POLARITY_BIT]) begin
				result <= {{4{data_sync[11]}}, data_sync};
			end else begin
				result <= {4'h0, data_sync};
			end
		end
	end

	// Sticky events; set wins over the clear on read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= adc_host_pkg::IRQ_RESET;
		end else begin
			irq_status <= (status_read ? 2'h0 : irq_status)
				| {conv_timeout, conv_end};
		end
	end
	assign irq = |(irq_status & irq_mask);

	// Read mux; option byte also mirrors busy in bit 7
	always_comb begin
		next_rdata = 32'h0;
		next_rerr = 1'b0;
		case (rd_index)
			adc_host_pkg::IDX_DONE_STATUS:
				next_rdata[adc_host_pkg::BUSY_BIT] = busy;
			adc_host_pkg::IDX_CONTROL:
				next_rdata[15:0] = result;
			adc_host_pkg::IDX_RESULT_HIGH:
				next_rdata[7:0] = result[15:8];
			adc_host_pkg::IDX_OPTION: begin
				next_rdata[adc_host_pkg::OPTION_BIT] = opt_sync;
				next_rdata[adc_host_pkg::BUSY_BIT] = busy;
			end
			adc_host_pkg::IDX_IRQ_STATUS:
				next_rdata[1:0] = irq_status;
			adc_host_pkg::IDX_IRQ_MASK:
				next_rdata[1:0] = irq_mask;
			default:
				next_rerr = 1'b1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
		end else if (read_fire) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Data and code are caught with the request, then held
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= adc_host_pkg::RESP_OKAY;
		end else if (read_fire) begin
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rerr ? adc_host_pkg::RESP_SLVERR
				: adc_host_pkg::RESP_OKAY;
		end
	end
endmodule
`default_nettype wire

// >>> hdl/adc_host_pkg.sv
// Purpose: constants for the conversion host port
// Assumes: 32-bit AXI4-Lite, word per register, index times four
// Notes: printed offsets are register indices
`default_nettype none
package adc_host_pkg;
	// Register indices; byte address is index times four
	localparam logic [29:0] IDX_DONE_STATUS = 30'h1080_0000;
	localparam logic [29:0] IDX_IRQ_STATUS = 30'h1080_0001;
	localparam logic [29:0] IDX_IRQ_MASK = 30'h1080_0002;
	localparam logic [29:0] IDX_CONTROL = 30'h10f0_0000;
	localparam logic [29:0] IDX_RESULT_HIGH = 30'h10f0_0001;
	localparam logic [29:0] IDX_OPTION = 30'h2240_0000;

	// Control byte fields
	localparam int CHAN_LSB = 0;
	localparam int POLARITY_BIT = 3;
	localparam int RANGE_BIT = 4;
	// Status byte field
	localparam int BUSY_BIT = 7;
	localparam int OPTION_BIT = 0;
	// Interrupt status fields
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TIMEOUT_BIT = 1;

	localparam logic [7:0] CONTROL_RESET = 8'h40;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Conversion time, longest wait rounds down
	localparam int CONV_TIME_NS = 12000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int COUNT_W = 12;
endpackage
`default_nettype wire
